/* rtl/stroke_pkg.sv */
/*
 Constants for the stroke limit supervisor: register offsets, fields,
 mode codes, error codes and timing.
 Assumes a 125 MHz ref_clk and 32-bit Wishbone data.
*/
package stroke_pkg;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_MODE = 8'h04;
  localparam logic [7:0] A_UPPER = 8'h08;
  localparam logic [7:0] A_LOWER = 8'h0C;
  localparam logic [7:0] A_FEED = 8'h10;
  localparam logic [7:0] A_ACTUAL = 8'h14;
  localparam logic [7:0] A_SPEED = 8'h18;
  localparam logic [7:0] A_START = 8'h1C;
  localparam logic [7:0] A_STATUS = 8'h20;
  localparam logic [7:0] A_TARGET = 8'h24;
  localparam logic [7:0] A_DECEL = 8'h28;
  localparam logic [7:0] A_RAPID = 8'h2C;
  // Control register fields
  localparam int C_UPDATE = 0;
  localparam int C_RAPID = 1;
  localparam int C_UNIT = 2;
  localparam logic [31:0] CTRL_MASK = 32'h0000000F;
  localparam logic [1:0] U_MM = 2'h0;
  localparam logic [1:0] U_INCH = 2'h1;
  localparam logic [1:0] U_DEGREE = 2'h2;
  localparam logic [1:0] U_PULSE = 2'h3;
  localparam int B_ABSOLUTE = 0;
  // Status register fields
  localparam int S_STATE = 16;
  localparam int S_DISABLED = 19;
  localparam int S_OSC_REFUSED = 20;
  localparam int S_FWD = 21;
  localparam int S_REV = 22;
  localparam int S_WRAPPED = 23;
  // Control modes
  localparam logic [3:0] M_POSITION = 4'h0;
  localparam logic [3:0] M_JOG = 4'h1;
  localparam logic [3:0] M_WHEEL = 4'h2;
  localparam logic [3:0] M_TORQUE = 4'h3;
  localparam logic [3:0] M_SPEED1 = 4'h4;
  localparam logic [3:0] M_SPEED2 = 4'h5;
  localparam logic [3:0] M_HOME = 4'h6;
  localparam logic [3:0] M_FOLLOW = 4'h7;
  localparam logic [3:0] M_FIXSTOP = 4'h8;
  localparam logic [3:0] M_SPDPOS = 4'h9;
  localparam logic [3:0] M_CIRC = 4'hA;
  localparam logic [3:0] M_HELIX = 4'hB;
  localparam logic [3:0] M_SWITCH = 4'hC;
  localparam logic [3:0] M_OSCIL = 4'hD;
  // Minor error codes
  localparam logic [15:0] E_NONE = 16'h0000;
  localparam logic [15:0] E_CIRC = 16'h006B;
  localparam logic [15:0] E_HELIX = 16'h006C;
  localparam logic [15:0] E_SWITCH = 16'h0077;
  localparam logic [15:0] E_LIMIT = 16'h00CF;
  localparam logic [15:0] E_NEG_HOME = 16'h012D;
  localparam logic [15:0] E_NEG_TRACK = 16'h0131;
  localparam logic [15:0] E_NEG_OTHER = 16'h0136;
  localparam logic [31:0] FEED_MAX = 32'h7FFFFFFF;
  localparam logic [31:0] FEED_MIN = 32'h80000000;
  localparam logic [31:0] DECEL_RST = 32'h00000001;
  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int OP_CYCLE_US = 1000;
  localparam int OP_CYCLE_CYCLES = OP_CYCLE_US * 1000 / CLK_PERIOD_NS;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_DECEL = 3'b100
  } motion_e;
endpackage : stroke_pkg

/* rtl/stroke_limit_supervisor.sv */
/*
 Stroke limit supervisor for one axis: travel-limit checks per operation
 cycle, recovery direction, limit-disabled feed and speed change policy.
 Assumes a classic Wishbone master and limit switch pins that are
 asynchronous to ref_clk; one instance per axis.
*/
// Chosen here: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
module stroke_limit_supervisor
  import stroke_pkg::*;
#(
  parameter int OP_TICKS = OP_CYCLE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic forward_limit_input,
  input wire logic reverse_limit_input,
  output logic motion_active,
  output logic limit_error
);
  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] val, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[i*8 +: 8] = val[i*8 +: 8];
    end
    return r;
  endfunction : merge

  function automatic logic [31:0] mag(input logic [31:0] v);
    return v[31] ? 32'(-v) : v;
  endfunction : mag

  // Braking distance v*v/(2*rate) compared without a divider
  function automatic logic overrun(input logic [31:0] m,
      input logic [32:0] room, input logic [31:0] rate);
    logic [65:0] sq;
    logic [65:0] reach;
    sq = 66'(m) * 66'(m);
    reach = (66'(rate) * 66'(room)) << 1;
    return sq > reach;
  endfunction : overrun

  motion_e state, next_state;
  logic [31:0] ctrl, upper, lower, feed, actual, speed, target;
  logic [31:0] decel_rate, rapid_rate, vel, remain;
  logic [3:0] mode, next_mode;
  logic [15:0] err, next_err;
  logic [31:0] next_feed, next_vel, next_remain;
  logic rapid, next_rapid, osc_ref, next_osc;
  logic [31:0] div_cnt;
  logic tick;
  logic [2:0] fwd_s, rev_s;
  logic fwd_q, rev_q;

  // Bus decode
  wire bus_req = wb_cyc_i & wb_stb_i;
  wire wr_hit = bus_req & wb_ack_o & wb_we_i;
  wire wr_ctrl = wr_hit && wb_adr_i == A_CTRL;
  wire wr_mode = wr_hit && wb_adr_i == A_MODE;
  wire wr_upper = wr_hit && wb_adr_i == A_UPPER;
  wire wr_lower = wr_hit && wb_adr_i == A_LOWER;
  wire wr_feed = wr_hit && wb_adr_i == A_FEED;
  wire wr_speed = wr_hit && wb_adr_i == A_SPEED;
  wire wr_start = wr_hit && wb_adr_i == A_START;
  wire wr_status = wr_hit && wb_adr_i == A_STATUS;
  wire wr_target = wr_hit && wb_adr_i == A_TARGET;
  wire wr_decel = wr_hit && wb_adr_i == A_DECEL;
  wire wr_rapid = wr_hit && wb_adr_i == A_RAPID;
  wire [31:0] wval = merge(32'h00000000, wb_dat_i, wb_sel_i);
  wire [31:0] status = {8'h00, 1'b0, rev_q, fwd_q, osc_ref,
                        1'b0, state, err};
  wire [31:0] rd_data =
    wb_adr_i == A_CTRL ? ctrl :
    wb_adr_i == A_MODE ? {28'h0000000, mode} :
    wb_adr_i == A_UPPER ? upper :
    wb_adr_i == A_LOWER ? lower :
    wb_adr_i == A_FEED ? feed :
    wb_adr_i == A_ACTUAL ? actual :
    wb_adr_i == A_SPEED ? speed :
    wb_adr_i == A_STATUS ? status :
    wb_adr_i == A_TARGET ? target :
    wb_adr_i == A_DECEL ? decel_rate :
    wb_adr_i == A_RAPID ? rapid_rate : 32'h00000000;

  // Limit geometry
  wire lim_off = upper == lower;
  wire wrapped = $signed(upper) < $signed(lower);
  wire above = $signed(feed) > $signed(upper);
  wire below = $signed(feed) < $signed(lower);
  wire hi_out = !lim_off && !wrapped && above;
  wire lo_out = !lim_off && !wrapped && below;
  wire pos_ok = !hi_out;
  wire neg_ok = !lo_out;
  wire upd = ctrl[C_UPDATE];
  wire [1:0] unit = ctrl[C_UNIT +: 2];
  wire checks_on = !lim_off && !wrapped && (mode == M_JOG ||
    mode == M_WHEEL || mode == M_TORQUE || mode == M_POSITION ||
    (mode == M_SPEED1 && upd));
  wire brake_mode = mode == M_JOG || mode == M_POSITION ||
    mode == M_SPEED1;
  // 33-bit sum so a checked axis outside torque mode never wraps past its limit
  wire signed [32:0] next33 = $signed({feed[31], feed}) +
    $signed({vel[31], vel});
  wire [31:0] next_pos = next33[31:0];
  wire cross_hi = !vel[31] && next33 > $signed({upper[31], upper});
  wire cross_lo = vel[31] && next33 < $signed({lower[31], lower});
  wire [32:0] room_hi = 33'({upper[31], upper} - {feed[31], feed});
  wire [32:0] room_lo = 33'({feed[31], feed} - {lower[31], lower});
  wire brake_hi = vel != 32'h0 && !vel[31] && !hi_out &&
    overrun(mag(vel), room_hi, decel_rate);
  wire brake_lo = vel[31] && !lo_out &&
    overrun(mag(vel), room_lo, decel_rate);
  wire blocked = (mode == M_JOG || mode == M_WHEEL) &&
    ((vel != 32'h0 && !vel[31] && !pos_ok) || (vel[31] && !neg_ok));
  wire [31:0] feed_lim = checks_on && cross_hi ? upper :
    checks_on && cross_lo ? lower : next_pos;
  wire clamped = checks_on && (cross_hi || cross_lo);
  wire [31:0] rate = rapid ? rapid_rate : decel_rate;
  wire fwd_fall = fwd_q && fwd_s[1] == fwd_s[2] && !fwd_s[2];
  wire rev_fall = rev_q && rev_s[1] == rev_s[2] && !rev_s[2];
  wire lim_fall = fwd_fall || rev_fall;
  // Shortest path on a disabled axis falls out of 32-bit wrap
  wire [31:0] to_go = wb_dat_i[B_ABSOLUTE] ? 32'(target - feed) :
    target;
  wire [31:0] dir_speed = to_go[31] ? 32'(-mag(speed)) : mag(speed);
  wire neg_req = wval[31] && lim_off;
  wire [15:0] neg_code =
    mode == M_HOME ? E_NEG_HOME :
    (mode == M_FOLLOW || mode == M_FIXSTOP || mode == M_SPDPOS) ?
      E_NEG_TRACK :
    (mode == M_JOG || mode == M_WHEEL || mode == M_TORQUE ||
     mode == M_SPEED1 || mode == M_SPEED2) ? E_NONE : E_NEG_OTHER;
  wire neg_accept = mode == M_SPEED1 || mode == M_SPEED2;

  always_comb begin
    next_state = state;
    next_vel = vel;
    next_feed = feed;
    next_remain = remain;
    next_mode = mode;
    next_rapid = rapid;
    next_osc = osc_ref;
    next_err = err;
    if (wr_status) next_err = E_NONE;
    if (wr_status) next_osc = 1'b0;
    if (wr_mode) next_mode = wval[3:0];
    if (wr_feed && state == ST_IDLE) next_feed = wval;
    if (tick) begin
      case (state)
        ST_RUN: begin
          if (blocked) begin
            next_feed = feed;
          end else if (mode == M_WHEEL && clamped) begin
            next_feed = feed_lim;
            next_vel = 32'h00000000;
            next_err = E_LIMIT;
          end else if (mode == M_TORQUE && clamped) begin
            next_feed = next_pos;
            next_err = E_LIMIT;
            next_mode = M_POSITION;
            next_state = ST_DECEL;
            next_rapid = 1'b0;
          end else if (checks_on && brake_mode &&
                       (brake_hi || brake_lo)) begin
            next_feed = feed_lim;
            next_err = E_LIMIT;
            next_state = ST_DECEL;
            next_rapid = 1'b0;
            if (clamped) next_vel = 32'h00000000;
          end else if (mode == M_POSITION &&
                       mag(remain) <= mag(vel)) begin
            next_feed = 32'(feed + remain);
            next_remain = 32'h00000000;
            next_vel = 32'h00000000;
            next_state = ST_IDLE;
          end else begin
            next_feed = feed_lim;
            next_remain = 32'(remain - vel);
            if (clamped) next_vel = 32'h00000000;
          end
        end
        ST_DECEL: begin
          next_feed = feed_lim;
          if (clamped || mag(vel) <= rate) begin
            next_vel = 32'h00000000;
            next_state = ST_IDLE;
          end else begin
            next_vel = vel[31] ? 32'(vel + rate) : 32'(vel - rate);
          end
        end
        default: ;
      endcase
    end
    if (lim_fall && state != ST_IDLE) begin
      next_state = ST_DECEL;
      next_rapid = ctrl[C_RAPID];
    end
    if (wr_start && state == ST_IDLE) begin
      if ((mode == M_CIRC || mode == M_HELIX) && lim_off &&
          unit == U_DEGREE) begin
        next_err = mode == M_CIRC ? E_CIRC : E_HELIX;
      end else if (mode == M_SWITCH && lim_off &&
                   wb_dat_i[B_ABSOLUTE] && unit != U_DEGREE) begin
        next_err = E_SWITCH;
      end else if (mode == M_OSCIL && lim_off) begin
        next_osc = 1'b1;
      end else if (mode == M_POSITION) begin
        next_remain = to_go;
        next_vel = dir_speed;
        next_state = ST_RUN;
      end else begin
        next_vel = speed;
        next_state = ST_RUN;
      end
    end
    if (wr_speed && state == ST_RUN) begin
      if (neg_req && !neg_accept) begin
        if (neg_code != E_NONE) next_err = neg_code;
      end else if (mode != M_POSITION) begin
        next_vel = wval;
      end
    end
  end

  // Operation cycle divider
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt <= 32'h00000000;
      tick <= 1'b0;
    end else begin
      tick <= div_cnt == 32'(OP_TICKS - 1);
      div_cnt <= div_cnt == 32'(OP_TICKS - 1) ? 32'h00000000 :
        32'(div_cnt + 32'h00000001);
    end
  end

  // Limit pins: three flops, a change counts when the last two agree
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      fwd_s <= 3'h7;
      rev_s <= 3'h7;
      fwd_q <= 1'b1;
      rev_q <= 1'b1;
    end else begin
      fwd_s <= {fwd_s[1:0], forward_limit_input};
      rev_s <= {rev_s[1:0], reverse_limit_input};
      if (fwd_s[1] == fwd_s[2]) fwd_q <= fwd_s[2];
      if (rev_s[1] == rev_s[2]) rev_q <= rev_s[2];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req & !wb_ack_o;
      wb_dat_o <= bus_req & !wb_ack_o ? rd_data : 32'h00000000;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= 32'h00000000;
      upper <= 32'h00000000;
      lower <= 32'h00000000;
      speed <= 32'h00000000;
      target <= 32'h00000000;
      decel_rate <= DECEL_RST;
      rapid_rate <= DECEL_RST;
    end else begin
      if (wr_ctrl) ctrl <= merge(ctrl, wb_dat_i, wb_sel_i) & CTRL_MASK;
      if (wr_upper) upper <= merge(upper, wb_dat_i, wb_sel_i);
      if (wr_lower) lower <= merge(lower, wb_dat_i, wb_sel_i);
      if (wr_speed) speed <= merge(speed, wb_dat_i, wb_sel_i);
      if (wr_target) target <= merge(target, wb_dat_i, wb_sel_i);
      if (wr_decel) decel_rate <= merge(decel_rate, wb_dat_i, wb_sel_i);
      if (wr_rapid) rapid_rate <= merge(rapid_rate, wb_dat_i, wb_sel_i);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      mode <= M_POSITION;
      feed <= 32'h00000000;
      actual <= 32'h00000000;
      vel <= 32'h00000000;
      remain <= 32'h00000000;
      err <= E_NONE;
      rapid <= 1'b0;
      osc_ref <= 1'b0;
      motion_active <= 1'b0;
      limit_error <= 1'b0;
    end else begin
      state <= next_state;
      mode <= next_mode;
      feed <= next_feed;
      if (tick) actual <= feed;
      vel <= next_vel;
      remain <= next_remain;
      err <= next_err;
      rapid <= next_rapid;
      osc_ref <= next_osc;
      motion_active <= next_state != ST_IDLE;
      limit_error <= next_err != E_NONE;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence run_tick_s;
    tick && state == ST_RUN && !wr_hit && !lim_fall;
  endsequence
  sequence start_s;
    wr_start && state == ST_IDLE && lim_off;
  endsequence

  jog_brake_a: assert property (run_tick_s ##0 mode == M_JOG &&
    checks_on && !blocked && (brake_hi || brake_lo)
    |=> err == E_LIMIT && state == ST_DECEL)
    else $error("jog overrun not braked");
  recover_dir_a: assert property (run_tick_s ##0 mode == M_JOG &&
    hi_out && vel != 32'h0 && !vel[31] |=> feed == $past(feed))
    else $error("outward move allowed above upper limit");
  wrap_both_a: assert property (run_tick_s ##0 mode == M_JOG &&
    wrapped && !lim_off |=> feed == 32'($past(feed) + $past(vel)))
    else $error("recovery blocked on wrapped range");
  wheel_stop_a: assert property (run_tick_s ##0 mode == M_WHEEL &&
    !blocked && checks_on && cross_hi
    |=> feed == $past(upper) && vel == 32'h0 && err == E_LIMIT)
    else $error("handwheel not stopped at limit");
  torque_pos_a: assert property (run_tick_s ##0 mode == M_TORQUE &&
    clamped |=> mode == M_POSITION && err == E_LIMIT)
    else $error("torque overrun not switched");
  speed1_skip_a: assert property (run_tick_s ##0 mode == M_SPEED1 &&
    !upd |=> state == ST_RUN)
    else $error("speed mode checked without update bit");
  limit_off_a: assert property (lim_fall && state != ST_IDLE &&
    !wr_ctrl |=> state == ST_DECEL && rapid == ctrl[C_RAPID])
    else $error("limit input off did not decelerate");
  unlimited_a: assert property (lim_off |-> !checks_on)
    else $error("checks active on disabled axis");
  wrap_top_a: assert property (run_tick_s ##0 lim_off &&
    mode == M_JOG && feed == FEED_MAX && vel == 32'h1
    |=> feed == FEED_MIN)
    else $error("feed did not wrap");
  circ_refuse_a: assert property (start_s ##0 mode == M_CIRC &&
    unit == U_DEGREE |=> err == E_CIRC && state == ST_IDLE)
    else $error("circular start not refused");
  switch_refuse_a: assert property (start_s ##0 mode == M_SWITCH &&
    wb_dat_i[B_ABSOLUTE] && unit != U_DEGREE
    |=> err == E_SWITCH && state == ST_IDLE)
    else $error("speed switching start not refused");
  neg_home_a: assert property (wr_speed && state == ST_RUN &&
    neg_req && mode == M_HOME |=> err == E_NEG_HOME && $stable(vel))
    else $error("home negative speed accepted");
  neg_quiet_a: assert property (wr_speed && state == ST_RUN &&
    neg_req && mode == M_JOG && !tick && !lim_fall
    |=> $stable(vel) && $stable(err))
    else $error("jog negative speed not ignored quietly");
endmodule : stroke_limit_supervisor

/* dv/limit_switch_model.sv */
/*
 Far-side model: the axis limit switches seen by the supervisor.
 Assumes the bench commands a trip; pins are high while travel is ok.
*/
`timescale 1ns/1ps
module limit_switch_model (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic trip_fwd,
  input wire logic trip_rev,
  output logic forward_limit_input,
  output logic reverse_limit_input
);
  // Switch contacts open on a trip; the pin falls for the supervisor
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      forward_limit_input <= 1'b1;
      reverse_limit_input <= 1'b1;
    end else begin
      forward_limit_input <= !trip_fwd;
      reverse_limit_input <= !trip_rev;
    end
  end
endmodule : limit_switch_model

/* dv/stroke_limit_supervisor_tb.sv */
/*
 Self-checking bench for the stroke limit supervisor over Wishbone.
 Assumes a one-cycle ack and a short operation cycle of OPT clocks.
*/
`timescale 1ns/1ps
module stroke_limit_supervisor_tb;
  import stroke_pkg::*;
  localparam int OPT = 8;
  logic ref_clk, rst_b, we, cyc, stb, ack, trip_fwd, trip_rev;
  logic fwd_pin, rev_pin, motion_active, limit_error;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, q, prev;
  logic [3:0] sel;
  int failures, n_checks, i;
  logic [3:0] modes [5] = '{M_HOME, M_FOLLOW, M_FIXSTOP, M_SPDPOS, 4'hE};
  logic [15:0] codes [5] = '{E_NEG_HOME, E_NEG_TRACK, E_NEG_TRACK,
    E_NEG_TRACK, E_NEG_OTHER};
  logic [3:0] rmode [3] = '{M_CIRC, M_HELIX, M_SWITCH};
  logic [31:0] rctrl [3] = '{32'h00000008, 32'h00000008, 32'h00000000};
  logic [15:0] rcode [3] = '{E_CIRC, E_HELIX, E_SWITCH};

  stroke_limit_supervisor #(.OP_TICKS(OPT)) uut (.ref_clk(ref_clk),
    .rst_b(rst_b), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(q),
    .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_ack_o(ack), .forward_limit_input(fwd_pin),
    .reverse_limit_input(rev_pin), .motion_active(motion_active),
    .limit_error(limit_error));
  limit_switch_model sw (.ref_clk(ref_clk), .rst_b(rst_b),
    .trip_fwd(trip_fwd), .trip_rev(trip_rev),
    .forward_limit_input(fwd_pin), .reverse_limit_input(rev_pin));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic conclude;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic check(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // One classic cycle; request held until ack is sampled high
  task automatic bus(input logic [7:0] a, input logic w,
      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    adr <= a;
    we <= w;
    wdat <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rdat = q;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 20) begin
      failures++;
      conclude();
    end
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    bus(a, 1'b0, 32'h00000000);
  endtask : rd

  task automatic ticks(input int n);
    repeat (n * OPT) @(posedge ref_clk);
  endtask : ticks

  task automatic err(input logic [15:0] e);
    rd(A_STATUS);
    check("error code", {16'h0000, rdat[15:0]}, {16'h0000, e});
  endtask : err

  // Fresh reset, then axis set-up; limits kept inside 32-bit range
  task automatic setup(input logic [31:0] c, input logic [3:0] m,
      input logic [31:0] up, input logic [31:0] lo, input logic [31:0] f,
      input logic [31:0] s);
    @(posedge ref_clk);
    rst_b <= 1'b0;
    trip_fwd <= 1'b0;
    trip_rev <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    wr(A_CTRL, c);
    wr(A_UPPER, up);
    wr(A_LOWER, lo);
    wr(A_FEED, f);
    wr(A_MODE, {28'h0000000, m});
    wr(A_SPEED, s);
  endtask : setup

  initial begin
    {cyc, stb, we, trip_fwd, trip_rev} = 5'b00000;
    adr = 8'h00;
    wdat = 32'h00000000;
    sel = 4'hF;
    rst_b = 1'b0;
    failures = 0;
    n_checks = 0;
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(A_CTRL);
    check("ctrl", rdat, 32'h00000000);
    rd(A_DECEL);
    check("decel", rdat, DECEL_RST);
    rd(A_STATUS);
    check("state", {29'h0, rdat[18:16]}, 32'h00000001);
    rd(8'h40);
    check("unmapped", rdat, 32'h00000000);
    // Equal limits: unlimited feed wraps past the top
    setup(32'h0, M_JOG, 32'h0, 32'h0, FEED_MAX, 32'h00000001);
    wr(A_START, 32'h0);
    ticks(3);
    rd(A_FEED);
    check("wrap", {31'h0, rdat[31]}, 32'h00000001);
    prev = rdat;
    wr(A_SPEED, 32'hFFFFFFFF);
    ticks(2);
    err(E_NONE);
    // Ignored change: feed keeps climbing at the old speed
    rd(A_FEED);
    check("jog speed kept", {31'h0, $signed(rdat) > $signed(prev)}, 32'h1);
    rd(A_ACTUAL);
    check("actual wrap", {31'h0, rdat[31]}, 32'h00000001);
    for (i = 0; i < 5; i++) begin
      setup(32'h0, modes[i], 32'h0, 32'h0, 32'h0, 32'h00000001);
      wr(A_START, 32'h0);
      ticks(2);
      wr(A_SPEED, 32'hFFFFFFFF);
      err(codes[i]);
      check("limit_error", {31'h0, limit_error}, 32'h00000001);
    end
    for (i = 0; i < 3; i++) begin
      setup(rctrl[i], rmode[i], 32'h0, 32'h0, 32'h0, 32'h00000001);
      wr(A_START, {31'h0, i == 2});
      ticks(2);
      err(rcode[i]);
      check("active", {31'h0, motion_active}, 32'h0);
    end
    setup(32'h0, M_OSCIL, 32'h0, 32'h0, 32'h0, 32'h00000001);
    wr(A_START, 32'h0);
    rd(A_STATUS);
    check("osc refused", {31'h0, rdat[S_OSC_REFUSED]}, 32'h1);
    // Absolute move across the wrap point goes the short way up
    setup(32'h0, M_POSITION, 32'h0, 32'h0, 32'h7FFFFFF0, 32'h00000010);
    wr(A_TARGET, 32'h80000010);
    wr(A_START, 32'h00000001);
    ticks(6);
    rd(A_FEED);
    check("shortest", rdat, 32'h80000010);
    check("shortest done", {31'h0, motion_active}, 32'h0);
    setup(32'h0, M_WHEEL, 32'd100, 32'd0, 32'd95, 32'd10);
    wr(A_START, 32'h0);
    ticks(3);
    rd(A_FEED);
    check("wheel stop", rdat, 32'd100);
    err(E_LIMIT);
    // Braking distance 1250 exceeds room 1000 at the first tick
    setup(32'h0, M_JOG, 32'd1000, 32'd0, 32'd0, 32'd50);
    wr(A_START, 32'h0);
    ticks(80);
    err(E_LIMIT);
    rd(A_FEED);
    check("brake", {31'h0, $signed(rdat) <= 1000}, 32'h1);
    check("brake stop", {31'h0, motion_active}, 32'h0);
    setup(32'h8, M_JOG, 32'd100, 32'd0, 32'd200, 32'hFFFFFFFB);
    wr(A_START, 32'h0);
    ticks(3);
    rd(A_FEED);
    check("inward", {31'h0, $signed(rdat) < 200}, 32'h1);
    setup(32'h8, M_JOG, 32'd100, 32'd0, 32'd200, 32'd5);
    wr(A_START, 32'h0);
    ticks(3);
    rd(A_FEED);
    check("outward", rdat, 32'd200);
    setup(32'h8, M_JOG, 32'd0, 32'd100, 32'd200, 32'd5);
    wr(A_START, 32'h0);
    ticks(3);
    rd(A_FEED);
    check("either", {31'h0, $signed(rdat) > 200}, 32'h1);
    setup(32'h0, M_TORQUE, 32'd100, 32'd0, 32'd90, 32'd20);
    wr(A_START, 32'h0);
    ticks(3);
    err(E_LIMIT);
    rd(A_MODE);
    check("mode", rdat, {28'h0, M_POSITION});
    setup(32'h0, M_SPEED1, 32'd100, 32'd0, 32'd95, 32'd10);
    wr(A_START, 32'h0);
    ticks(3);
    err(E_NONE);
    setup(32'h1, M_SPEED1, 32'd100, 32'd0, 32'd95, 32'd10);
    wr(A_START, 32'h0);
    ticks(3);
    err(E_LIMIT);
    setup(32'h0, M_JOG, 32'h0, 32'h0, 32'h0, 32'd5);
    wr(A_START, 32'h0);
    ticks(2);
    trip_fwd <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rd(A_STATUS);
    check("pin stop", {29'h0, rdat[18:16]}, 32'h00000004);
    check("fwd pin", {31'h0, rdat[S_FWD]}, 32'h0);
    // Rapid rate 5 stops speed -5 in one tick; normal rate 1 would not
    setup(32'h2, M_JOG, 32'h0, 32'h0, 32'h0, 32'hFFFFFFFB);
    wr(A_RAPID, 32'h00000005);
    wr(A_START, 32'h0);
    ticks(2);
    trip_rev <= 1'b1;
    ticks(3);
    rd(A_STATUS);
    check("rapid stop", {29'h0, rdat[18:16]}, 32'h00000001);
    check("rev pin", {31'h0, rdat[S_REV]}, 32'h0);
    conclude();
  end
endmodule : stroke_limit_supervisor_tb
